// File: common/dso_pkg.sv
package dso_pkg;
	// Register byte offsets on the AXI4-Lite port.
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_START  = 8'h04;
	localparam logic [7:0] REG_TOL    = 8'h08;
	localparam logic [7:0] REG_DET1   = 8'h0C;
	localparam logic [7:0] REG_DET1R  = 8'h10;
	localparam logic [7:0] REG_DET2   = 8'h14;
	localparam logic [7:0] REG_HYST   = 8'h18;
	localparam logic [7:0] REG_STATUS = 8'h1C;
	localparam logic [7:0] REG_TERM0  = 8'h20;
	// Values after reset, then limits, the reverse sentinel and the PM threshold; frequencies are in 0.01 Hz steps.
	localparam logic [15:0] RST_START = 16'h0032;
	localparam logic [6:0]  RST_TOL   = 7'h0A;
	localparam logic [15:0] RST_DET1  = 16'h0258;
	localparam logic [15:0] RST_DET1R = 16'h270F;
	localparam logic [15:0] RST_DET2  = 16'h0BB8;
	localparam logic [15:0] RST_HYST  = 16'h0000;
	localparam logic [15:0] REV_SAME  = 16'h270F;
	localparam logic [15:0] MAX_FREQ  = 16'h9C40;
	localparam logic [15:0] MAX_HYST  = 16'h01F4;
	localparam logic [6:0]  MAX_TOL   = 7'h64;
	localparam logic [15:0] PM_FREQ   = 16'h0001;
	// Assignment codes, base part and polarity split.
	localparam logic [6:0] CODE_ACTIVE = 7'h00;
	localparam logic [6:0] CODE_SPEED  = 7'h01;
	localparam logic [6:0] CODE_FD1    = 7'h04;
	localparam logic [6:0] CODE_FD2    = 7'h05;
	localparam logic [6:0] CODE_READY  = 7'h0B;
	localparam logic [6:0] CODE_CMD    = 7'h2D;
	localparam logic [6:0] CODE_MC     = 7'h5B;
	localparam logic [6:0] CODE_SEC    = 7'h5E;
	localparam logic [6:0] CODE_PRIM   = 7'h63;
	localparam logic [7:0] NEG_BASE    = 8'h64;
	localparam logic [7:0] CODE_LIMIT  = 8'hC8;
	localparam logic [7:0] CODE_NONE   = 8'hFF;
	// Pole detection delay under permanent-magnet control.
	localparam int PM_DELAY_MS  = 100;
	localparam int CLK_HZ       = 50000000;
	localparam int PM_DELAY_CYC = PM_DELAY_MS * (CLK_HZ / 1000);
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		PM_IDLE = 2'b00,
		PM_WAIT = 2'b01,
		PM_DONE = 2'b10
	} dso_pm_e;

	typedef struct packed {
		logic        awvalid;
		logic [7:0]  awaddr;
		logic        wvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bready;
		logic        arvalid;
		logic [7:0]  araddr;
		logic        rready;
	} dso_axi_req_s;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} dso_axi_rsp_s;

	typedef struct packed {
		logic        canOperate;
		logic        running;
		logic        stopped;
		logic        dcBraking;
		logic        outputShutoff;
		logic        powerFail;
		logic        tripped;
		logic        faultResetting;
		logic [7:0]  hwFault;
		logic        reverse;
		logic [15:0] outFreq;
		logic [15:0] setFreq;
		logic        forwardStartCmd;
		logic        reverseStartCmd;
	} dso_drive_s;

	typedef struct packed {
		logic operationReady;
		logic active;
		logic commandedActive;
		logic primaryFault;
		logic secondaryFault;
		logic contactorShutoff;
		logic atSpeed;
		logic freqDetectOne;
		logic freqDetectTwo;
	} dso_stat_s;
endpackage : dso_pkg

// File: rtl/dso_top.sv
// Function
// - Ready when able to operate or running.
// - Active at or above starting frequency.
// - Active off while stopped or braking.
// - Commanded-active needs start and running, output shutoff or able to operate.
// - Commanded-active follows start despite fault.
// - Codes 11/111, 0/100, 45/145.
// - Ready held but drops on power failure.
// - Shutoff: active low, commanded follows start.
// - Permanent-magnet mode delays active 100ms.
// - Active routed to its terminal by default.
// - Trip raises primary and secondary fault.
// - Secondary held through reset; codes 94/194.
// - Primary fault on first relay by default.
// - Contactor shutoff on hardware faults; 91/191.
// - Listed hardware faults raise contactor shutoff.
// - At-speed when output reaches set frequency.
// - Tolerance 0 to 100 percent, default 10.
// - Detect one threshold, default 6Hz; 4/104.
// - Reverse threshold; 9999 means use forward.
// - Detect two threshold, default 30Hz; 5/105.
// - Hysteresis 0 to 5Hz, default 0Hz.
// - Codes below 100 positive, 100-199 negative.
// - Hysteresis stops detection outputs from chattering.
//
// Decided for this implementation: the address map and the AXI4-Lite register port.
`timescale 1ns/10ps
module dso_top #(
	parameter int N_TERM       = 7,
	parameter int PM_DELAY_CYC = dso_pkg::PM_DELAY_CYC
) (
	input  wire logic                 clk_sys,
	input  wire logic                 rst_b,
	input  wire dso_pkg::dso_axi_req_s axiReq,
	output      dso_pkg::dso_axi_rsp_s axiRsp,
	input  wire dso_pkg::dso_drive_s   drive,
	output      dso_pkg::dso_stat_s    status,
	output      logic [N_TERM-1:0]     terminal
);
	// The terminal registers must fit below the top of the 8-bit map.
	if (N_TERM < 2 || N_TERM > 16) begin : g_badTerm
		$error("N_TERM must lie between 2 and 16.");
	end
	// The pole wait compares its counter against PM_DELAY_CYC - 2, so one cycle cannot be served.
	if (PM_DELAY_CYC < 2) begin : g_badDelay
		$error("PM_DELAY_CYC must be at least two.");
	end
	// Merge write data into a 16-bit field under the byte strobes.
	function automatic logic [15:0] mergeStrb(input logic [15:0] old,
			input logic [31:0] data, input logic [3:0] strb);
		return {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
	endfunction : mergeStrb
	// Index of a terminal register, or N_TERM when not one.
	function automatic int termIndex(input logic [7:0] addr);
		int idx;
		idx = int'((addr - dso_pkg::REG_TERM0) >> 2);
		return (addr < dso_pkg::REG_TERM0 || addr[1:0] != 2'h0 || idx >= N_TERM) ?
				N_TERM : idx;
	endfunction : termIndex
	// Upper bound on a frequency field, keeping the reverse sentinel.
	function automatic logic [15:0] clampF(input logic [15:0] v,
			input logic [15:0] lim);
		return (v > lim) ? lim : v;
	endfunction : clampF
	logic        pmMode_q;
	logic [15:0] startFreq_q;
	logic [6:0]  tol_q;
	logic [15:0] det1_q;
	logic [15:0] det1Rev_q;
	logic [15:0] det2_q;
	logic [15:0] hyst_q;
	logic [7:0]  termCode_q [N_TERM];
	logic        awready_q;
	logic        wready_q;
	logic        bvalid_q;
	logic [1:0]  bresp_q;
	logic [7:0]  awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0]  wstrb_q;
	logic        arready_q;
	logic        rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0]  rresp_q;
	logic        doWrite;
	logic        wrMapped;
	int          wrTerm;
	int          rdTerm;
	dso_pkg::dso_stat_s stat_q;
	dso_pkg::dso_pm_e   pmState_q;
	logic [31:0]        pmCount_q;
	logic [N_TERM-1:0]  term_q;
	// Address and data may arrive in either order; each ready drops
	// once its item is held and rises again after the response.
	assign doWrite = ~awready_q & ~wready_q & ~bvalid_q;
	assign wrTerm  = termIndex(awaddr_q);
	assign rdTerm  = termIndex(axiReq.araddr);
	assign wrMapped = (awaddr_q <= dso_pkg::REG_HYST && awaddr_q[1:0] == 2'h0)
			|| (wrTerm < N_TERM);

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			awready_q <= 1'b1;
			wready_q  <= 1'b1;
			bvalid_q  <= 1'b0;
			bresp_q   <= dso_pkg::RESP_OKAY;
			awaddr_q  <= 8'h00;
			wdata_q   <= 32'h00000000;
			wstrb_q   <= 4'h0;
		end else begin
			if (axiReq.awvalid && awready_q) begin
				awready_q <= 1'b0;
				awaddr_q  <= axiReq.awaddr;
			end
			if (axiReq.wvalid && wready_q) begin
				wready_q <= 1'b0;
				wdata_q  <= axiReq.wdata;
				wstrb_q  <= axiReq.wstrb;
			end
			if (doWrite) begin
				bvalid_q <= 1'b1;
				bresp_q  <= wrMapped ? dso_pkg::RESP_OKAY : dso_pkg::RESP_SLVERR;
			end
			if (bvalid_q && axiReq.bready) begin
				bvalid_q  <= 1'b0;
				awready_q <= 1'b1;
				wready_q  <= 1'b1;
			end
		end
	end
	// Configuration registers; out-of-range settings are clamped.
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			pmMode_q    <= 1'b0;
			startFreq_q <= dso_pkg::RST_START;
			tol_q       <= dso_pkg::RST_TOL;
			det1_q      <= dso_pkg::RST_DET1;
			det1Rev_q   <= dso_pkg::RST_DET1R;
			det2_q      <= dso_pkg::RST_DET2;
			hyst_q      <= dso_pkg::RST_HYST;
			for (int i = 0; i < N_TERM; i++) begin
				termCode_q[i] <= dso_pkg::CODE_NONE;
			end
			termCode_q[0]        <= {1'b0, dso_pkg::CODE_ACTIVE};
			termCode_q[N_TERM-1] <= {1'b0, dso_pkg::CODE_PRIM};
		end else if (doWrite) begin
			case (awaddr_q)
				dso_pkg::REG_CTRL: begin
					if (wstrb_q[0]) begin
						pmMode_q <= wdata_q[0];
					end
				end
				dso_pkg::REG_START: begin
					startFreq_q <= clampF(mergeStrb(startFreq_q, wdata_q, wstrb_q),
							dso_pkg::MAX_FREQ);
				end
				dso_pkg::REG_TOL: begin
					if (wstrb_q[0]) begin
						tol_q <= (wdata_q[7:0] > {1'b0, dso_pkg::MAX_TOL}) ?
								dso_pkg::MAX_TOL : wdata_q[6:0];
					end
				end
				dso_pkg::REG_DET1: begin
					det1_q <= clampF(mergeStrb(det1_q, wdata_q, wstrb_q),
							dso_pkg::MAX_FREQ);
				end
				dso_pkg::REG_DET1R: begin
					det1Rev_q <= clampF(mergeStrb(det1Rev_q, wdata_q, wstrb_q),
							dso_pkg::MAX_FREQ);
				end
				dso_pkg::REG_DET2: begin
					det2_q <= clampF(mergeStrb(det2_q, wdata_q, wstrb_q),
							dso_pkg::MAX_FREQ);
				end
				dso_pkg::REG_HYST: begin
					hyst_q <= clampF(mergeStrb(hyst_q, wdata_q, wstrb_q),
							dso_pkg::MAX_HYST);
				end
				default: begin
					if (wrTerm < N_TERM && wstrb_q[0]) begin
						termCode_q[wrTerm] <= wdata_q[7:0];
					end
				end
			endcase
		end
	end
	// Read channel: one read at a time, unmapped offsets answer SLVERR.
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			arready_q <= 1'b1;
			rvalid_q  <= 1'b0;
			rdata_q   <= 32'h00000000;
			rresp_q   <= dso_pkg::RESP_OKAY;
		end else if (axiReq.arvalid && arready_q) begin
			arready_q <= 1'b0;
			rvalid_q  <= 1'b1;
			rresp_q   <= dso_pkg::RESP_OKAY;
			case (axiReq.araddr)
				dso_pkg::REG_CTRL:   rdata_q <= {31'h00000000, pmMode_q};
				dso_pkg::REG_START:  rdata_q <= {16'h0000, startFreq_q};
				dso_pkg::REG_TOL:    rdata_q <= {25'h0000000, tol_q};
				dso_pkg::REG_DET1:   rdata_q <= {16'h0000, det1_q};
				dso_pkg::REG_DET1R:  rdata_q <= {16'h0000, det1Rev_q};
				dso_pkg::REG_DET2:   rdata_q <= {16'h0000, det2_q};
				dso_pkg::REG_HYST:   rdata_q <= {16'h0000, hyst_q};
				dso_pkg::REG_STATUS: rdata_q <= {20'h00000, pmState_q, 1'b0, stat_q};
				default: begin
					if (rdTerm < N_TERM) begin
						rdata_q <= {24'h000000, termCode_q[rdTerm]};
					end else begin
						rdata_q <= 32'h00000000;
						rresp_q <= dso_pkg::RESP_SLVERR;
					end
				end
			endcase
		end else if (rvalid_q && axiReq.rready) begin
			rvalid_q  <= 1'b0;
			arready_q <= 1'b1;
		end
	end

	assign axiRsp = '{awready: awready_q, wready: wready_q, bvalid: bvalid_q,
			bresp: bresp_q, arready: arready_q, rvalid: rvalid_q,
			rdata: rdata_q, rresp: rresp_q};
	// Pole detection wait: restarts on every fresh start command.
	logic startCmd;
	assign startCmd = drive.forwardStartCmd | drive.reverseStartCmd;
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			pmState_q <= dso_pkg::PM_IDLE;
			pmCount_q <= 32'h00000000;
		end else begin
			case (pmState_q)
				dso_pkg::PM_IDLE: begin
					pmCount_q <= 32'h00000000;
					if (startCmd) begin
						pmState_q <= dso_pkg::PM_WAIT;
					end
				end
				dso_pkg::PM_WAIT: begin
					pmCount_q <= pmCount_q + 32'h00000001;
					if (!startCmd) begin
						pmState_q <= dso_pkg::PM_IDLE;
					end else if (pmCount_q >= 32'(PM_DELAY_CYC - 2)) begin
						pmState_q <= dso_pkg::PM_DONE;
					end
				end
				dso_pkg::PM_DONE: begin
					if (!startCmd) begin
						pmState_q <= dso_pkg::PM_IDLE;
					end
				end
				default: pmState_q <= dso_pkg::PM_IDLE;
			endcase
		end
	end

	// Frequency comparisons. Widened to 17 bits so adding hysteresis
	// to a full-scale output frequency or at-speed band cannot wrap.
	logic [15:0] runThresh;
	logic [15:0] det1Sel;
	logic [22:0] bandProd;
	logic [22:0] bandQuot;
	logic [16:0] diff;
	logic [16:0] bandOn;
	logic [16:0] bandOff;
	logic        fd1On;
	logic        fd1Off;
	logic        fd2On;
	logic        fd2Off;

	assign runThresh = pmMode_q ? dso_pkg::PM_FREQ : startFreq_q;
	assign det1Sel = (drive.reverse && det1Rev_q != dso_pkg::REV_SAME) ?
			det1Rev_q : det1_q;
	assign bandProd = drive.setFreq * tol_q;
	assign bandQuot = bandProd / 23'h000064;
	assign diff = (drive.outFreq >= drive.setFreq) ?
			{1'b0, drive.outFreq - drive.setFreq} :
			{1'b0, drive.setFreq - drive.outFreq};
	assign bandOn  = {1'b0, bandQuot[15:0]};
	assign bandOff = bandOn + {1'b0, hyst_q};
	assign fd1On  = drive.outFreq >= det1Sel;
	assign fd1Off = {1'b0, drive.outFreq} + {1'b0, hyst_q} < {1'b0, det1Sel};
	assign fd2On  = drive.outFreq >= det2_q;
	assign fd2Off = {1'b0, drive.outFreq} + {1'b0, hyst_q} < {1'b0, det2_q};

	// Status flops; each detection keeps its state inside the band.
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			stat_q <= '0;
		end else begin
			stat_q.operationReady <= (drive.canOperate | drive.running)
					& ~drive.powerFail & ~drive.tripped;
			stat_q.active <= (drive.outFreq >= runThresh)
					& ~drive.stopped & ~drive.dcBraking
					& ~drive.outputShutoff
					& (~pmMode_q | pmState_q == dso_pkg::PM_DONE);
			stat_q.commandedActive <= startCmd & (drive.running
					| drive.outputShutoff | drive.canOperate);
			stat_q.primaryFault <= drive.tripped;
			stat_q.secondaryFault <= drive.tripped
					| (stat_q.secondaryFault & drive.faultResetting);
			stat_q.contactorShutoff <= drive.tripped & (|drive.hwFault);
			if (diff <= bandOn) begin
				stat_q.atSpeed <= 1'b1;
			end else if (diff > bandOff) begin
				stat_q.atSpeed <= 1'b0;
			end
			if (fd1On) begin
				stat_q.freqDetectOne <= 1'b1;
			end else if (fd1Off) begin
				stat_q.freqDetectOne <= 1'b0;
			end
			if (fd2On) begin
				stat_q.freqDetectTwo <= 1'b1;
			end else if (fd2Off) begin
				stat_q.freqDetectTwo <= 1'b0;
			end
		end
	end

	// Status picked by the base part of an assignment code.
	function automatic logic statusOf(input logic [6:0] base,
			input dso_pkg::dso_stat_s s);
		case (base)
			dso_pkg::CODE_ACTIVE: return s.active;
			dso_pkg::CODE_SPEED:  return s.atSpeed;
			dso_pkg::CODE_FD1:    return s.freqDetectOne;
			dso_pkg::CODE_FD2:    return s.freqDetectTwo;
			dso_pkg::CODE_READY:  return s.operationReady;
			dso_pkg::CODE_CMD:    return s.commandedActive;
			dso_pkg::CODE_MC:     return s.contactorShutoff;
			dso_pkg::CODE_SEC:    return s.secondaryFault;
			dso_pkg::CODE_PRIM:   return s.primaryFault;
			default:              return 1'b0;
		endcase
	endfunction : statusOf

	// Terminal drivers. Reading the registered status costs one cycle
	// of latency but keeps every terminal glitch free.
	for (genvar t = 0; t < N_TERM; t++) begin : g_term
		logic [7:0] code;
		logic       isNeg;
		logic [6:0] base;
		assign code  = termCode_q[t];
		assign isNeg = code >= dso_pkg::NEG_BASE;
		assign base  = isNeg ? 7'(code - dso_pkg::NEG_BASE) : code[6:0];
		always_ff @(posedge clk_sys) begin
			if (!rst_b) begin
				term_q[t] <= 1'b0;
			end else if (code >= dso_pkg::CODE_LIMIT) begin
				term_q[t] <= 1'b0;
			end else begin
				term_q[t] <= statusOf(base, stat_q) ^ isNeg;
			end
		end
	end

	assign status   = stat_q;
	assign terminal = term_q;
	// Checks on the status and terminal logic.
	AST_READY_PF: assert property (@(posedge clk_sys) disable iff (!rst_b)
		drive.powerFail |=> !status.operationReady)
		else $error("Ready stayed high during power failure.");
	AST_READY_ON: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(drive.running && !drive.powerFail && !drive.tripped)
		|=> status.operationReady)
		else $error("Ready low while running.");
	AST_ACT_STOP: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(drive.stopped || drive.dcBraking || drive.outputShutoff)
		|=> !status.active)
		else $error("Active high while stopped, braking or shut off.");
	AST_CMD_START: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(startCmd && drive.outputShutoff) |=> status.commandedActive)
		else $error("Commanded-active missing under shutoff.");
	AST_CMD_OFF: assert property (@(posedge clk_sys) disable iff (!rst_b)
		!startCmd |=> !status.commandedActive)
		else $error("Commanded-active without start command.");
	AST_FAULT_BOTH: assert property (@(posedge clk_sys) disable iff (!rst_b)
		$rose(drive.tripped) |=> (status.primaryFault && status.secondaryFault))
		else $error("Trip did not raise both fault statuses.");
	AST_SEC_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(status.secondaryFault && drive.faultResetting) |=> status.secondaryFault)
		else $error("Secondary fault dropped during reset period.");
	AST_MC: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(drive.tripped && drive.hwFault != 8'h00) |=> status.contactorShutoff)
		else $error("Contactor shutoff missing on hardware fault.");
	AST_PM_DELAY: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(pmMode_q && pmState_q != dso_pkg::PM_DONE) |=> !status.active)
		else $error("Active rose before pole detection ended.");
	AST_FD2_HYST: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(status.freqDetectTwo && !fd2Off) |=> status.freqDetectTwo)
		else $error("Detect two dropped inside hysteresis band.");
	AST_TERM: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(termCode_q[0] == 8'h64 && $stable(termCode_q[0]))
		|-> terminal[0] == !$past(stat_q.active))
		else $error("Negative polarity terminal wrong.");
endmodule : dso_top

// File: verif/dso_relay_model.sv
`timescale 1ns/10ps
// Contactor seen from the drive terminal: the coil pulls in two edges after it is energised.
// The delay mimics armature travel, so the bench cannot rely on an instant contact.
module dso_relay_model (
	input  wire logic clk_sys,
	input  wire logic rst_b,
	input  wire logic coilDrive,
	output logic      contactOpen
);
	logic armature_q;

	// Armature and contact follow the coil one edge apart.
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			armature_q  <= 1'h0;
			contactOpen <= 1'h0;
		end else begin
			armature_q  <= coilDrive;
			contactOpen <= armature_q;
		end
	end
endmodule : dso_relay_model

// File: verif/tb.sv
`timescale 1ns/10ps
module tb;
	logic                  clk_sys;
	logic                  rst_b;
	dso_pkg::dso_axi_req_s axiReq;
	dso_pkg::dso_axi_rsp_s axiRsp;
	dso_pkg::dso_drive_s   drive;
	dso_pkg::dso_stat_s    status;
	logic [6:0]            terminal;
	logic                  contactOpen;
	logic [31:0]           rd;
	logic [1:0]            rr;
	logic [7:0]            codes [12];
	logic                  expT [12];
	int                    n_mismatch;
	int                    checks;
	int                    cycles;

	dso_top #(.N_TERM(7), .PM_DELAY_CYC(20)) u_dut (
		.clk_sys (clk_sys),
		.rst_b   (rst_b),
		.axiReq  (axiReq),
		.axiRsp  (axiRsp),
		.drive   (drive),
		.status  (status),
		.terminal(terminal)
	);

	dso_relay_model u_relay (
		.clk_sys    (clk_sys),
		.rst_b      (rst_b),
		.coilDrive  (terminal[2]),
		.contactOpen(contactOpen)
	);

	// Free-running system clock, 20 ns period.
	always #10 clk_sys = ~clk_sys;

	// Hang guard: the whole sequence needs well under a thousand cycles.
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 5000) begin
			n_mismatch++;
			summarize();
		end
	end

	task automatic summarize();
		$display("Checks %0d, mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : summarize

	task automatic chkWord(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask : chkWord

	task automatic chkBit(input string name, input logic exp, input logic got);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error %s expected %b seen %b", name, exp, got);
		end
	endtask : chkBit

	// Both channels offered together; each is released at the edge that takes it.
	// One idle edge after the response keeps back-to-back calls from driving a strobe twice.
	task automatic axiWrite(input logic [7:0] a, input logic [31:0] d);
		axiReq.awvalid <= 1'h1;
		axiReq.awaddr  <= a;
		axiReq.wvalid  <= 1'h1;
		axiReq.wdata   <= d;
		axiReq.wstrb   <= 4'hF;
		axiReq.bready  <= 1'h1;
		do begin
			@(posedge clk_sys);
			if (axiReq.awvalid && axiRsp.awready) axiReq.awvalid <= 1'h0;
			if (axiReq.wvalid && axiRsp.wready) axiReq.wvalid <= 1'h0;
		end while (!(axiRsp.bvalid && axiReq.bready));
		axiReq.bready <= 1'h0;
		@(posedge clk_sys);
	endtask : axiWrite

	// Only the bench timeout ends a wait that never gets its answer.
	task automatic axiRead(input logic [7:0] a);
		axiReq.arvalid <= 1'h1;
		axiReq.araddr  <= a;
		axiReq.rready  <= 1'h1;
		do begin
			@(posedge clk_sys);
			if (axiReq.arvalid && axiRsp.arready) axiReq.arvalid <= 1'h0;
		end while (!(axiRsp.rvalid && axiReq.rready));
		rd = axiRsp.rdata;
		rr = axiRsp.rresp;
		axiReq.rready <= 1'h0;
		@(posedge clk_sys);
	endtask : axiRead

	task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
		axiRead(a);
		chkWord("rresp", dso_pkg::RESP_OKAY, {30'h0, rr});
		chkWord("rdata", exp, rd);
	endtask : rdChk

	// Status lags inputs by one edge and terminals by one more; four edges cover both.
	task automatic settle();
		repeat (4) @(posedge clk_sys);
	endtask : settle

	initial begin
		clk_sys = 1'h0;
		rst_b = 1'h0;
		axiReq = '0;
		drive = '0;
		n_mismatch = 0;
		checks = 0;
		cycles = 0;
		codes = '{8'h0B, 8'h6F, 8'h2D, 8'h91, 8'h04, 8'h68, 8'h05, 8'h69, 8'h01, 8'h65, 8'hC8, 8'h00};
		expT = '{1'h1, 1'h0, 1'h0, 1'h1, 1'h1, 1'h0, 1'h0, 1'h1, 1'h0, 1'h1, 1'h0, 1'h1};
		repeat (20) @(posedge clk_sys);
		rst_b <= 1'h1;
		@(posedge clk_sys);
		rdChk(dso_pkg::REG_START, 32'h0000_0032);
		rdChk(dso_pkg::REG_TOL, 32'h0000_000A);
		rdChk(dso_pkg::REG_DET1, 32'h0000_0258);
		rdChk(dso_pkg::REG_DET1R, 32'h0000_270F);
		rdChk(dso_pkg::REG_DET2, 32'h0000_0BB8);
		rdChk(dso_pkg::REG_HYST, 32'h0000_0000);
		rdChk(dso_pkg::REG_TERM0, 32'h0000_0000);
		rdChk(8'h38, 32'h0000_0063);
		axiRead(8'h3C);
		chkWord("unmapped", dso_pkg::RESP_SLVERR, {30'h0, rr});
		// Ready, then lost on power failure.
		drive.canOperate <= 1'h1;
		settle();
		chkBit("ready", 1'h1, status.operationReady);
		drive.powerFail <= 1'h1;
		settle();
		chkBit("readyPf", 1'h0, status.operationReady);
		drive.powerFail <= 1'h0;
		// Active exactly at the starting frequency, lost one step below and when braking.
		drive.running <= 1'h1;
		drive.outFreq <= 16'h0032;
		settle();
		chkBit("active", 1'h1, status.active);
		chkBit("term0", 1'h1, terminal[0]);
		drive.outFreq <= 16'h0031;
		settle();
		chkBit("activeLow", 1'h0, status.active);
		drive.outFreq <= 16'h0032;
		drive.dcBraking <= 1'h1;
		settle();
		chkBit("activeDc", 1'h0, status.active);
		drive.dcBraking <= 1'h0;
		drive.stopped <= 1'h1;
		settle();
		chkBit("activeStop", 1'h0, status.active);
		drive.stopped <= 1'h0;
		drive.forwardStartCmd <= 1'h1;
		settle();
		chkBit("cmdRun", 1'h1, status.commandedActive);
		// Output shut off: active held low while the commanded status follows start.
		drive.outputShutoff <= 1'h1;
		drive.running <= 1'h0;
		settle();
		chkBit("cmdShut", 1'h1, status.commandedActive);
		chkBit("activeShut", 1'h0, status.active);
		drive.forwardStartCmd <= 1'h0;
		settle();
		chkBit("cmdOff", 1'h0, status.commandedActive);
		drive.outputShutoff <= 1'h0;
		// Trip on each hardware fault class in turn.
		axiWrite(8'h24, 32'h0000_00C2);
		axiWrite(8'h28, 32'h0000_005B);
		drive.tripped <= 1'h1;
		for (int i = 0; i < 8; i++) begin
			drive.hwFault <= 8'(8'h01 << i);
			settle();
			chkBit("mcOff", 1'h1, status.contactorShutoff);
		end
		chkBit("prim", 1'h1, status.primaryFault);
		chkBit("sec", 1'h1, status.secondaryFault);
		chkBit("term6", 1'h1, terminal[6]);
		chkBit("termSecNeg", 1'h0, terminal[1]);
		chkBit("relay", 1'h1, contactOpen);
		drive.tripped <= 1'h0;
		drive.faultResetting <= 1'h1;
		settle();
		chkBit("secHold", 1'h1, status.secondaryFault);
		chkBit("primOff", 1'h0, status.primaryFault);
		chkBit("mcGone", 1'h0, status.contactorShutoff);
		drive.faultResetting <= 1'h0;
		drive.hwFault <= 8'h00;
		// At-speed band edges: 10 percent, then zero tolerance.
		drive.running <= 1'h1;
		drive.setFreq <= 16'h03E8;
		drive.outFreq <= 16'h0384;
		settle();
		chkBit("speed", 1'h1, status.atSpeed);
		drive.outFreq <= 16'h0383;
		settle();
		chkBit("speedOut", 1'h0, status.atSpeed);
		axiWrite(dso_pkg::REG_TOL, 32'h0000_0000);
		drive.outFreq <= 16'h03E8;
		settle();
		chkBit("speedZero", 1'h1, status.atSpeed);
		// Detection thresholds, reverse default and override.
		drive.outFreq <= 16'h0258;
		settle();
		chkBit("fd1", 1'h1, status.freqDetectOne);
		drive.reverse <= 1'h1;
		settle();
		chkBit("fd1RevSame", 1'h1, status.freqDetectOne);
		axiWrite(dso_pkg::REG_DET1R, 32'h0000_03E8);
		settle();
		chkBit("fd1Rev", 1'h0, status.freqDetectOne);
		drive.reverse <= 1'h0;
		drive.outFreq <= 16'h0257;
		settle();
		chkBit("fd1Low", 1'h0, status.freqDetectOne);
		axiWrite(dso_pkg::REG_HYST, 32'h0000_0064);
		drive.outFreq <= 16'h0BB8;
		settle();
		chkBit("fd2", 1'h1, status.freqDetectTwo);
		drive.outFreq <= 16'h0B86;
		settle();
		chkBit("fd2Hyst", 1'h1, status.freqDetectTwo);
		drive.outFreq <= 16'h0B53;
		settle();
		chkBit("fd2Off", 1'h0, status.freqDetectTwo);
		// Code table on one terminal: ready on, commanded off, detect one on, two off.
		for (int i = 0; i < 12; i++) begin
			axiWrite(8'h2C, {24'h0, codes[i]});
			settle();
			chkBit("term3", expT[i], terminal[3]);
		end
		axiWrite(8'h2C, 32'h0000_0091);
		settle();
		chkBit("cmdNeg", 1'h1, terminal[3]);
		// Status word: ready, active and detect one set, pole wait idle.
		rdChk(dso_pkg::REG_STATUS, 32'h0000_0182);
		// Active on its own terminal with negative polarity.
		axiWrite(dso_pkg::REG_TERM0, 32'h0000_0064);
		settle();
		chkBit("term0Neg", 1'h0, terminal[0]);
		// Permanent-magnet start waits for pole detection.
		axiWrite(dso_pkg::REG_CTRL, 32'h0000_0001);
		drive.outFreq <= 16'h0001;
		drive.reverseStartCmd <= 1'h1;
		settle();
		chkBit("pmWait", 1'h0, status.active);
		repeat (30) @(posedge clk_sys);
		chkBit("pmActive", 1'h1, status.active);
		summarize();
	end
endmodule : tb
